// ---- pkg/p1sd_pkg.sv ----
// constants for the port 1 soft-strap default loader
//
// Overview of operation
// - speed strap sets rate select bit default: low 10 Mbps, high 100 Mbps, tie-off high
// - speed strap also sets 10BASE-T advertise bits 6 and 5 and operating field
// - duplex strap sets duplex mode bit default: low half, high full, tie-off high
// - duplex strap also sets 10BASE-T full-duplex advertise bit 6 and operating field
// - backpressure strap sets port 1 backpressure enable default; tie-off high
// - pause strap sets both transmit and receive pause enable defaults; tie-off high
// - strap pause enables apply only while manual pause selection is in effect
// - straps captured once the settle count reaches SETTLE_CYCLES after hardware reset release; loader values replace them when present
// - soft reset or reload without loader reverts to captured values, no re-sampling
package p1sd_pkg;
   localparam int STRAP_W = 4;
   localparam int S_SPEED = 3;
   localparam int S_DUPLEX = 2;
   localparam int S_BP = 1;
   localparam int S_PAUSE = 0;
   localparam logic [3:0] STRAP_TIEOFF = 4'hF;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;
   // register byte offsets
   localparam logic [7:0] OFS_BASIC = 8'h00;
   localparam logic [7:0] OFS_ADV = 8'h04;
   localparam logic [7:0] OFS_SPECIAL = 8'h08;
   localparam logic [7:0] OFS_MANUAL = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // field positions
   localparam int B_RATE = 13;
   localparam int B_DUPLEX = 8;
   localparam int B_ADV_10FD = 6;
   localparam int B_ADV_10HD = 5;
   localparam int B_MODE_LO = 5;
   localparam int B_RXP = 0;
   localparam int B_TXP = 1;
   localparam int B_BP = 2;
   localparam int B_MSEL = 3;
   localparam int B_OVR = 4;
   localparam logic MANUAL_SEL_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {REG_BASIC, REG_ADV, REG_SPECIAL, REG_MANUAL, REG_STATUS, REG_NONE} p1sd_reg_t;
endpackage

// ---- rtl/p1sd_sync.sv ----
// two-stage synchroniser for strap pins
`timescale 1ns/1ps
module p1sd_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // p1sd_sync

// ---- rtl/p1sd_top.sv ----
// port 1 soft-strap defaults with axi4-lite register access
`timescale 1ns/1ps
module p1sd_top
   import p1sd_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [STRAP_W-1:0] strap_pins,
   input wire logic eeprom_present,
   input wire logic eeprom_load,
   input wire logic [STRAP_W-1:0] eeprom_straps,
   input wire logic soft_reload,
   input wire logic aneg_tx_pause,
   input wire logic aneg_rx_pause,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic rate_100_out,
   output logic full_duplex_out,
   output logic [2:0] phy_mode_out,
   output logic backpressure_out,
   output logic tx_pause_out,
   output logic rx_pause_out
);
   function automatic p1sd_reg_t decode(input logic [ADDR_W-1:0] a);
      case (a[7:0])
         OFS_BASIC: decode = REG_BASIC;
         OFS_ADV: decode = REG_ADV;
         OFS_SPECIAL: decode = REG_SPECIAL;
         OFS_MANUAL: decode = REG_MANUAL;
         OFS_STATUS: decode = REG_STATUS;
         default: decode = REG_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // strap capture and override
   logic [STRAP_W-1:0] pins_sync;
   logic [STRAP_W-1:0] latched_r, ee_r;
   logic [1:0] settle_r;
   logic captured_r, ovr_r, apply_r;
   wire capture = !captured_r && settle_r == SETTLE_CYCLES;
   wire ee_take = eeprom_load && eeprom_present;
   wire revert = soft_reload && !eeprom_present;
   wire [STRAP_W-1:0] eff = ovr_r ? ee_r : latched_r;

   p1sd_sync #(.WIDTH(STRAP_W), .RST_VAL(STRAP_TIEOFF)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(strap_pins),
      .q(pins_sync)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_r <= 2'h0;
         captured_r <= 1'b0;
         latched_r <= STRAP_TIEOFF;
         ee_r <= STRAP_TIEOFF;
         ovr_r <= 1'b0;
         apply_r <= 1'b0;
      end else begin
         if (!captured_r && settle_r != SETTLE_CYCLES)
            settle_r <= settle_r + 2'h1;
         if (capture) begin
            captured_r <= 1'b1;
            latched_r <= pins_sync;
         end
         if (ee_take) begin
            ee_r <= eeprom_straps;
            ovr_r <= 1'b1;
         end else if (revert)
            ovr_r <= 1'b0;
         apply_r <= capture || ee_take || soft_reload;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_held_r, w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   wire p1sd_reg_t wsel = decode(awaddr_r);
   wire p1sd_reg_t rsel = decode(s_axi_araddr);
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire wr_basic = do_write && wsel == REG_BASIC && wstrb_r[1];
   wire wr_adv = do_write && wsel == REG_ADV && wstrb_r[0];
   wire wr_spec = do_write && wsel == REG_SPECIAL && wstrb_r[0];
   wire wr_man = do_write && wsel == REG_MANUAL && wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         s_axi_awready <= !aw_held_r && !aw_fire && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !w_fire && !s_axi_bvalid;
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control bits: strap defaults load, then software owns them
   logic rate_r, duplex_r, adv_fd_r, adv_hd_r, bp_r, txp_r, rxp_r, msel_r;
   logic [2:0] mode_r;
   wire [2:0] mode_dflt = {1'b0, eff[S_SPEED], eff[S_DUPLEX]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {rate_r, duplex_r} <= STRAP_TIEOFF[S_SPEED -: 2];
         adv_fd_r <= 1'b0;
         adv_hd_r <= 1'b0;
         mode_r <= {1'b0, STRAP_TIEOFF[S_SPEED -: 2]};
         bp_r <= STRAP_TIEOFF[S_BP];
         {txp_r, rxp_r} <= {2{STRAP_TIEOFF[S_PAUSE]}};
         msel_r <= MANUAL_SEL_RST;
      end else if (apply_r) begin
         rate_r <= eff[S_SPEED];
         duplex_r <= eff[S_DUPLEX];
         adv_hd_r <= !eff[S_SPEED];
         adv_fd_r <= !eff[S_SPEED] && eff[S_DUPLEX];
         mode_r <= mode_dflt;
         bp_r <= eff[S_BP];
         txp_r <= eff[S_PAUSE];
         rxp_r <= eff[S_PAUSE];
      end else begin
         if (wr_basic) begin
            rate_r <= wdata_r[B_RATE];
            duplex_r <= wdata_r[B_DUPLEX];
         end
         if (wr_adv) begin
            adv_fd_r <= wdata_r[B_ADV_10FD];
            adv_hd_r <= wdata_r[B_ADV_10HD];
         end
         if (wr_spec)
            mode_r <= wdata_r[B_MODE_LO +: 3];
         if (wr_man) begin
            bp_r <= wdata_r[B_BP];
            txp_r <= wdata_r[B_TXP];
            rxp_r <= wdata_r[B_RXP];
            msel_r <= wdata_r[B_MSEL];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path and applied outputs
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0;
      case (rsel)
         REG_BASIC: begin
            rd_word[B_RATE] = rate_r;
            rd_word[B_DUPLEX] = duplex_r;
         end
         REG_ADV: begin
            rd_word[B_ADV_10FD] = adv_fd_r;
            rd_word[B_ADV_10HD] = adv_hd_r;
         end
         REG_SPECIAL: rd_word[B_MODE_LO +: 3] = mode_r;
         REG_MANUAL: rd_word[B_MSEL:0] = {msel_r, bp_r, txp_r, rxp_r};
         REG_STATUS: rd_word[B_OVR:0] = {ovr_r, latched_r};
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
         rate_100_out <= 1'b0;
         full_duplex_out <= 1'b0;
         phy_mode_out <= 3'h0;
         backpressure_out <= 1'b0;
         tx_pause_out <= 1'b0;
         rx_pause_out <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         rate_100_out <= rate_r;
         full_duplex_out <= duplex_r;
         phy_mode_out <= mode_r;
         backpressure_out <= bp_r;
         tx_pause_out <= msel_r ? txp_r : aneg_tx_pause;
         rx_pause_out <= msel_r ? rxp_r : aneg_rx_pause;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_revert;
      revert ##1 apply_r;
   endsequence

   a_rate_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> rate_r == $past(eff[S_SPEED])) else $error("rate bit not loaded from strap");
   a_adv_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> adv_hd_r == !$past(eff[S_SPEED]) && adv_fd_r == ($past(eff) >= 4'h4 && $past(eff) < 4'h8))
      else $error("advertise bits wrong after load");
   a_duplex_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> duplex_r == $past(eff[S_DUPLEX])) else $error("duplex bit not loaded");
   a_mode_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> mode_r == {1'b0, $past(eff[S_SPEED]), $past(eff[S_DUPLEX])}) else $error("mode field wrong");
   a_bp_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> bp_r == $past(eff[S_BP]) ##1 backpressure_out == $past(bp_r))
      else $error("backpressure default wrong");
   a_pause_load: assert property (@(posedge aclk) disable iff (!aresetn)
      apply_r |=> txp_r == $past(eff[S_PAUSE]) && rxp_r == txp_r) else $error("pause defaults wrong");
   a_pause_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !msel_r |=> tx_pause_out == $past(aneg_tx_pause) && rx_pause_out == $past(aneg_rx_pause))
      else $error("strap pause applied without manual select");
   a_capture_once: assert property (@(posedge aclk) disable iff (!aresetn)
      capture |=> latched_r == $past(pins_sync) ##1 !capture [*3]) else $error("strap capture wrong");
   a_revert_latched: assert property (@(posedge aclk) disable iff (!aresetn)
      s_revert |=> rate_r == latched_r[S_SPEED] && bp_r == latched_r[S_BP]) else $error("reload did not revert");
   a_sw_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_man && !apply_r |=> bp_r == $past(wdata_r[B_BP])) else $error("software write lost");
endmodule // p1sd_top

// ---- sim/p1sd_strap_model.sv ----
// strap pin and eeprom loader model facing the port 1 strap block
`timescale 1ns/1ps
module p1sd_strap_model
   import p1sd_pkg::*;
(
   input wire logic aclk,
   output logic [STRAP_W-1:0] strap_pins,
   output logic eeprom_present,
   output logic eeprom_load,
   output logic [STRAP_W-1:0] eeprom_straps,
   output logic soft_reload
);
   initial begin
      strap_pins = STRAP_TIEOFF;
      eeprom_present = 1'b0;
      eeprom_load = 1'b0;
      eeprom_straps = 4'h0;
      soft_reload = 1'b0;
   end
   task automatic set_pins(input logic [STRAP_W-1:0] v);
      strap_pins <= v;
   endtask
   // loader word is only valid during the load pulse, inverted afterwards
   task automatic push(input logic [STRAP_W-1:0] v, input logic pres);
      @(posedge aclk);
      eeprom_present <= pres;
      eeprom_straps <= v;
      eeprom_load <= 1'b1;
      @(posedge aclk);
      eeprom_load <= 1'b0;
      eeprom_straps <= ~v;
   endtask
   task automatic reload(input logic pres);
      @(posedge aclk);
      eeprom_present <= pres;
      soft_reload <= 1'b1;
      @(posedge aclk);
      soft_reload <= 1'b0;
   endtask
endmodule // p1sd_strap_model

// ---- sim/p1sd_top_tb.sv ----
// self-checking bench for the port 1 strap default block
`timescale 1ns/1ps
module p1sd_top_tb;
   import p1sd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic atx = 1'b0;
   logic arx = 1'b0;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic br = 1'b0;
   logic arv = 1'b0;
   logic rr = 1'b0;
   logic probe = 1'b0;
   logic awr, wrdy, bv, arr, rv, rate, fdx, bp, txp, rxp, eprs, eld, srl;
   logic [1:0] bresp, rresp;
   logic [31:0] rdat;
   logic [2:0] mode;
   logic [3:0] pins, estr;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [7:0] oq[$];
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   always #5 aclk = ~aclk;
   p1sd_strap_model i_model (.aclk(aclk), .strap_pins(pins), .eeprom_present(eprs), .eeprom_load(eld),
      .eeprom_straps(estr), .soft_reload(srl));
   p1sd_top i_dut (.aclk(aclk), .aresetn(aresetn), .strap_pins(pins), .eeprom_present(eprs), .eeprom_load(eld),
      .eeprom_straps(estr), .soft_reload(srl), .aneg_tx_pause(atx), .aneg_rx_pause(arx),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .rate_100_out(rate), .full_duplex_out(fdx), .phy_mode_out(mode),
      .backpressure_out(bp), .tx_pause_out(txp), .rx_pause_out(rxp));
   ////////////////////////////////////////
   task automatic note(input logic bad, input string what);
      num_checks++;
      if (bad) begin
         error_cnt++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
      note(g !== e, "read data or response");
   endtask
   task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
      note(g !== e, "write response");
   endtask
   task automatic cmp_out(input logic [7:0] g, input logic [7:0] e);
      note(g !== e, "applied outputs");
   endtask
   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // result watcher: pops the oldest note whenever a result shows up
   always @(posedge aclk) begin
      if (rv && rr) cmp_rd({rresp, rdat}, rq.pop_front());
      if (bv && br) cmp_b(bresp, bq.pop_front());
      if (probe) cmp_out({rate, fdx, mode, bp, txp, rxp}, oq.pop_front());
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   ////////////////////////////////////////
   task automatic hw_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wrdy));
      while (!bv) @(posedge aclk);
      br <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      while (!rv) @(posedge aclk);
      rr <= 1'b0;
   endtask
   task automatic chk_out(input logic [7:0] e);
      oq.push_back(e);
      @(posedge aclk);
      probe <= 1'b1;
      @(posedge aclk);
      probe <= 1'b0;
   endtask
   task automatic check_all(input logic [3:0] s, input logic [3:0] man);
      chk_out({s[3:2], 1'b0, s[3:2], man[2], man[3] ? man[1] : atx, man[3] ? man[0] : arx});
      axr(OFS_BASIC, {RESP_OKAY, 18'h0, s[3], 4'h0, s[2], 8'h00});
      axr(OFS_ADV, {RESP_OKAY, 25'h0, ~s[3] & s[2], ~s[3], 5'h00});
      axr(OFS_SPECIAL, {RESP_OKAY, 24'h0, 1'b0, s[3:2], 5'h00});
      axr(OFS_MANUAL, {RESP_OKAY, 28'h0, man});
   endtask
   ////////////////////////////////////////
   initial begin
      logic [3:0] p;
      logic [3:0] e;
      void'($urandom(78));
      for (int k = 0; k < 4; k++) begin
         p = (k == 3) ? STRAP_TIEOFF : {k[1:0], 2'($urandom)};
         atx <= 1'($urandom);
         arx <= 1'($urandom);
         i_model.set_pins(p);
         hw_reset();
         repeat (10) @(posedge aclk);
         check_all(p, {1'b0, p[1], p[0], p[0]});
         axr(OFS_STATUS, {RESP_OKAY, 28'h0, p});
      end
      axw(OFS_MANUAL, 32'h0000_000A, RESP_OKAY);
      axw(OFS_BASIC, 32'h0000_0000, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk_out({5'b00011, 3'b010});
      axw(OFS_MANUAL, 32'h0000_0004, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk_out({5'b00011, 1'b1, atx, arx});
      axr(OFS_BASIC, {RESP_OKAY, 32'h0});
      axw(OFS_ADV, 32'h0000_0040, RESP_OKAY);
      axw(OFS_SPECIAL, 32'h0000_00E0, RESP_OKAY);
      axr(OFS_ADV, {RESP_OKAY, 32'h0000_0040});
      axr(OFS_SPECIAL, {RESP_OKAY, 32'h0000_00E0});
      chk_out({5'b00111, 1'b1, atx, arx});
      axw(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
      axr(8'h14, {RESP_SLVERR, 32'h0});
      e = 4'($urandom);
      i_model.push(e, 1'b1);
      repeat (6) @(posedge aclk);
      check_all(e, {1'b0, e[1], e[0], e[0]});
      axr(OFS_STATUS, {RESP_OKAY, 27'h0, 1'b1, p});
      i_model.push(~e, 1'b0);
      i_model.set_pins(~p);
      repeat (6) @(posedge aclk);
      chk_out({e[3:2], 1'b0, e[3:2], e[1], atx, arx});
      i_model.reload(1'b0);
      repeat (6) @(posedge aclk);
      check_all(p, {1'b0, p[1], p[0], p[0]});
      axr(OFS_STATUS, {RESP_OKAY, 28'h0, p});
      conclude();
   end
endmodule // p1sd_top_tb
